// >>> common/ohp_if.sv
`timescale 1ns/1ps
interface ohp_if;
  logic       cs_n;         // Chip select, active low
  logic       chip_init_n;  // Initialisation, active low
  logic       rw;           // High read, low write
  logic       dc;           // High data, low command
  logic       e;            // Enable strobe
  logic [7:0] host_do;      // Host drive value
  logic       host_oe;      // Host drives bus
  logic [7:0] dev_do;       // Device drive value
  logic       dev_oe;       // Device drives bus
  logic [7:0] parallel_data_bus;
  // Resolved bus level; undriven reads low
  assign parallel_data_bus = host_oe ? host_do : (dev_oe ? dev_do : 8'h00);
  modport host (output cs_n, chip_init_n, rw, dc, e, host_do, host_oe,
                input dev_do, dev_oe, parallel_data_bus);
  modport device (input cs_n, chip_init_n, rw, dc, e, host_do, host_oe, parallel_data_bus,
                  output dev_do, dev_oe);
endinterface

// >>> common/ohp_pkg.sv
package ohp_pkg;
  // Bus geometry
  localparam int DATA_W = 8;
  // Transfer direction on the read/write select
  localparam logic RW_READ  = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  // Data/command select levels
  localparam logic DC_DATA = 1'b1;
  localparam logic DC_CMD  = 1'b0;
  // Host strobe timing: enable high and low phases, in ns
  // High phase outlasts the device's pin synchroniser lag, so read data stands at the fall
  localparam int E_HIGH_NS = 800;
  localparam int E_LOW_NS  = 300;
  localparam int CLK_NS    = 100;
  localparam int E_HIGH_CYC = (E_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int E_LOW_CYC  = (E_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W      = 4;
  // Input synchroniser depth
  localparam int SYNC_W = 3;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE  = 4'h1;
endpackage

// >>> rtl/ohp_device.sv
`timescale 1ns/1ps
// Functional notes
// - Respond only while chip select low
// - Initialisation low returns state to defaults
// - Host keeps initialisation high in operation
// - Read/write select high read, low write
// - Select high: byte is display data
// - Select low: byte goes to command
// - Enable strobe qualifies each transfer
// - Data bus bidirectional, direction by cycle
// - Host ties unused data lines low
module ohp_device #(
  parameter int DATA_W = ohp_pkg::DATA_W
) (
  input  wire logic              clk_i,       // System clock
  input  wire logic              rst_n_i,     // Async reset, active low
  ohp_if.device                  bus,         // Parallel port pins
  input  wire logic [DATA_W-1:0] rd_data_i,   // Byte returned on reads
  output logic      [DATA_W-1:0] cmd_o,       // Command register
  output logic                   cmd_vld_o,   // Command written pulse
  output logic      [DATA_W-1:0] wdata_o,     // Display data byte
  output logic                   wdata_vld_o, // Display data pulse
  output logic                   rd_ack_o     // Read cycle ended pulse
);
  localparam int SW = ohp_pkg::SYNC_W;
  localparam int NS = 4 + DATA_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages per pin
  logic [NS-1:0] pins;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [NS-1:0] s3;
  logic [NS-1:0] stable;
  assign pins = {bus.chip_init_n, bus.cs_n, bus.rw, bus.e, bus.parallel_data_bus};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      stable <= {1'b0, 1'b1, 1'b0, 1'b0, {DATA_W{1'b0}}};
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < NS; i++) begin
        if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  end
  // Data/command select sampled the same way
  logic [SW-1:0] dc_sh;
  logic          dc_st;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dc_sh <= '0;
      dc_st <= 1'b0;
    end else begin
      dc_sh <= {dc_sh[SW-2:0], bus.dc};
      if (dc_sh[1] == dc_sh[2]) begin
        dc_st <= dc_sh[2];
      end
    end
  end

  logic              init_n_s;
  logic              cs_n_s;
  logic              rw_s;
  logic              e_s;
  logic [DATA_W-1:0] d_s;
  assign {init_n_s, cs_n_s, rw_s, e_s, d_s} = stable;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer state
  logic              e_q;
  logic [DATA_W-1:0] cmd, next_cmd;
  logic [DATA_W-1:0] wd, next_wd;
  logic              cmd_v, next_cmd_v;
  logic              wd_v, next_wd_v;
  logic              ack, next_ack;
  logic              oe, next_oe;
  logic [DATA_W-1:0] dout, next_dout;
  logic              fall;

  // Next values
  always_comb begin
    fall       = e_q && !e_s;
    next_cmd   = cmd;
    next_wd    = wd;
    next_cmd_v = 1'b0;
    next_wd_v  = 1'b0;
    next_ack   = 1'b0;
    next_dout  = dout;
    next_oe    = 1'b0;
    if (!init_n_s) begin
      next_cmd  = ohp_pkg::BYTE_RST;
      next_wd   = ohp_pkg::BYTE_RST;
      next_dout = ohp_pkg::BYTE_RST;
    end else if (!cs_n_s) begin
      if (rw_s == ohp_pkg::RW_READ) begin
        next_oe   = e_s;
        next_dout = rd_data_i;
        next_ack  = fall;
      end else if (fall) begin
        if (dc_st == ohp_pkg::DC_DATA) begin
          next_wd   = d_s;
          next_wd_v = 1'b1;
        end else begin
          next_cmd   = d_s;
          next_cmd_v = 1'b1;
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      e_q   <= 1'b0;
      cmd   <= ohp_pkg::BYTE_RST;
      wd    <= ohp_pkg::BYTE_RST;
      cmd_v <= 1'b0;
      wd_v  <= 1'b0;
      ack   <= 1'b0;
      oe    <= 1'b0;
      dout  <= ohp_pkg::BYTE_RST;
    end else begin
      e_q   <= e_s;
      cmd   <= next_cmd;
      wd    <= next_wd;
      cmd_v <= next_cmd_v;
      wd_v  <= next_wd_v;
      ack   <= next_ack;
      oe    <= next_oe;
      dout  <= next_dout;
    end
  end

  assign cmd_o       = cmd;
  assign cmd_vld_o   = cmd_v;
  assign wdata_o     = wd;
  assign wdata_vld_o = wd_v;
  assign rd_ack_o    = ack;
  assign bus.dev_oe  = oe;
  assign bus.dev_do  = dout;
endmodule

// >>> rtl/ohp_host.sv
`timescale 1ns/1ps
module ohp_host #(
  parameter int DATA_W = ohp_pkg::DATA_W
) (
  input  wire logic              clk_i,      // System clock
  input  wire logic              rst_n_i,    // Async reset, active low
  ohp_if.host                    bus,        // Parallel port pins
  input  wire logic              init_req_i, // Hold device in init
  input  wire logic              req_i,      // Start a transfer
  input  wire logic              rw_i,       // High read, low write
  input  wire logic              dc_i,       // High data, low command
  input  wire logic [DATA_W-1:0] wdata_i,    // Byte to write
  output logic                   busy_o,     // Transfer in progress
  output logic                   done_o,     // Transfer finished pulse
  output logic      [DATA_W-1:0] rdata_o     // Byte read
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW  = 2'b10
  } ohp_hst_t;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencer state
  ohp_hst_t          st, next_st;
  logic [3:0]        cnt, next_cnt;
  logic              cs_n, next_cs_n;
  logic              rw, next_rw;
  logic              dc, next_dc;
  logic              e, next_e;
  logic              oe, next_oe;
  logic [DATA_W-1:0] dout, next_dout;
  logic [DATA_W-1:0] rd, next_rd;
  logic              done, next_done;
  logic              init_n, next_init_n;
  logic              busy, next_busy;

  // Next values
  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_cs_n   = cs_n;
    next_rw     = rw;
    next_dc     = dc;
    next_e      = e;
    next_oe     = oe;
    next_dout   = dout;
    next_rd     = rd;
    next_done   = 1'b0;
    next_init_n = !init_req_i;
    unique case (st)
      ST_IDLE: begin
        if (req_i && !init_req_i) begin
          next_cs_n = 1'b0;
          next_rw   = rw_i;
          next_dc   = dc_i;
          next_e    = 1'b1;
          next_oe   = (rw_i == ohp_pkg::RW_WRITE);
          next_dout = wdata_i;
          next_cnt  = 4'(ohp_pkg::E_HIGH_CYC);
          next_st   = ST_HIGH;
        end
      end
      ST_HIGH: begin
        next_cnt = cnt - ohp_pkg::CNT_ONE;
        if (cnt == ohp_pkg::CNT_ONE) begin
          next_e   = 1'b0;
          if (rw == ohp_pkg::RW_READ) begin
            next_rd = bus.parallel_data_bus;
          end
          next_cnt = 4'(ohp_pkg::E_LOW_CYC);
          next_st  = ST_LOW;
        end
      end
      ST_LOW: begin
        next_cnt = cnt - ohp_pkg::CNT_ONE;
        if (cnt == ohp_pkg::CNT_ONE) begin
          next_cs_n = 1'b1;
          next_oe   = 1'b0;
          next_dout = ohp_pkg::BYTE_RST;
          next_done = 1'b1;
          next_st   = ST_IDLE;
        end
      end
    endcase
    next_busy = (next_st != ST_IDLE);
  end

  // Registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st     <= ST_IDLE;
      cnt    <= ohp_pkg::CNT_ZERO;
      cs_n   <= 1'b1;
      rw     <= ohp_pkg::RW_WRITE;
      dc     <= ohp_pkg::DC_CMD;
      e      <= 1'b0;
      oe     <= 1'b0;
      dout   <= ohp_pkg::BYTE_RST;
      rd     <= ohp_pkg::BYTE_RST;
      done   <= 1'b0;
      init_n <= 1'b0;
      busy   <= 1'b0;
    end else begin
      st     <= next_st;
      cnt    <= next_cnt;
      cs_n   <= next_cs_n;
      rw     <= next_rw;
      dc     <= next_dc;
      e      <= next_e;
      oe     <= next_oe;
      dout   <= next_dout;
      rd     <= next_rd;
      done   <= next_done;
      init_n <= next_init_n;
      busy   <= next_busy;
    end
  end

  assign bus.cs_n        = cs_n;
  assign bus.chip_init_n = init_n;
  assign bus.rw          = rw;
  assign bus.dc          = dc;
  assign bus.e           = e;
  assign bus.host_oe     = oe;
  assign bus.host_do     = dout;
  assign busy_o          = busy;
  assign done_o          = done;
  assign rdata_o         = rd;
endmodule

// >>> tb/ohp_monitor.sv
`timescale 1ns/1ps
////////////////////
module ohp_monitor (
  input wire logic       clk_i,             // Clock
  input wire logic       rst_n_i,           // Reset, active low
  input wire logic       cs_n,              // Chip select
  input wire logic       chip_init_n,       // Init, active low
  input wire logic       rw,                // Read/write select
  input wire logic       dc,                // Data/command select
  input wire logic       e,                 // Strobe
  input wire logic [7:0] host_do,           // Host drive value
  input wire logic       host_oe,           // Host drives
  input wire logic       dev_oe             // Device drives
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////
  // Bus ownership and framing
  chk_dev_quiet: assert property (cs_n [*5] |-> !dev_oe)
    else $error("device drives while deselected");
  chk_no_fight: assert property (dev_oe |-> !host_oe)
    else $error("both ends drive the bus");
  chk_wr_drive: assert property (host_oe |-> rw == ohp_pkg::RW_WRITE && !cs_n)
    else $error("host drives outside a write");
  chk_host_quiet: assert property (cs_n |-> !host_oe)
    else $error("host drives while deselected");
  chk_init_idle: assert property (!chip_init_n |-> cs_n && !e)
    else $error("transfer during init");
  chk_strobe_sel: assert property (e |-> !cs_n)
    else $error("strobe without select");
  chk_hold_fields: assert property (e && $past(e) |-> $stable(rw) && $stable(dc) && $stable(host_do))
    else $error("fields move under strobe");
  chk_frame_shape: assert property ($fell(cs_n) |-> e [*8] ##1 (!e && !cs_n) [*3] ##1 cs_n)
    else $error("bad frame shape");
  // Main scenarios
  cov_write: cover property ($fell(cs_n) && rw == ohp_pkg::RW_WRITE);
  cov_read: cover property ($fell(cs_n) && rw == ohp_pkg::RW_READ);
  cov_init: cover property ($fell(chip_init_n));
endmodule

// >>> tb/oled_parallel_host_port_tb_top.sv
`timescale 1ns/1ps
////////////////////
module oled_parallel_host_port_tb_top;
  logic       clk_i, rst_n_i, init_req_i, req_i, rw_i, dc_i;
  logic [7:0] wdata_i, rd_data_i, cmd_o, wdata_o, rdata_o;
  logic       cmd_vld_o, wdata_vld_o, rd_ack_o, busy_o, done_o;
  logic [9:0] exp_q[$];
  int         fails, check_count, cyc;
  ohp_if bus_if();
  ohp_host ohp_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .init_req_i(init_req_i),
    .req_i(req_i), .rw_i(rw_i), .dc_i(dc_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
    .rdata_o(rdata_o));
  ohp_device ohp_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if), .rd_data_i(rd_data_i),
    .cmd_o(cmd_o), .cmd_vld_o(cmd_vld_o), .wdata_o(wdata_o), .wdata_vld_o(wdata_vld_o), .rd_ack_o(rd_ack_o));
  ohp_monitor ohp_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n(bus_if.cs_n),
    .chip_init_n(bus_if.chip_init_n), .rw(bus_if.rw), .dc(bus_if.dc), .e(bus_if.e),
    .host_do(bus_if.host_do), .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe));
  ////////////////////
  // Compare and count
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  // Counts and verdict
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One host transfer, expected device result queued
  task automatic xfer(input logic rw, input logic dc, input logic [7:0] b);
    int n;
    @(posedge clk_i);
    #1;
    req_i = 1'b1;
    rw_i = rw;
    dc_i = dc;
    wdata_i = b;
    rd_data_i = 8'($urandom);
    exp_q.push_back(rw ? 10'h200 : {1'b0, dc, b});
    @(posedge clk_i);
    #1;
    req_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(10'(done_o), 10'h1, "done");
    if (rw == ohp_pkg::RW_READ) begin
      check({2'b00, rdata_o}, {2'b00, rd_data_i}, "read data");
    end
  endtask
  // Drain queue
  task automatic settle(input string name);
    repeat (12) @(posedge clk_i);
    #1;
    check(10'(exp_q.size()), 10'h0, "queue empty");
    $display("test %s done", name);
  endtask
  ////////////////////
  // Device results against queued notes
  always @(negedge clk_i) begin
    if (cmd_vld_o === 1'b1 || wdata_vld_o === 1'b1 || rd_ack_o === 1'b1) begin
      check(rd_ack_o === 1'b1 ? 10'h200 : (wdata_vld_o === 1'b1 ? {2'b01, wdata_o} : {2'b00, cmd_o}),
        exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff, "device result");
    end
  end
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Hang limit
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(32'hf56254e1));
    {rst_n_i, init_req_i, req_i, rw_i, dc_i, wdata_i, rd_data_i} = '0;
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < 16; i++) begin
      xfer(ohp_pkg::RW_WRITE, i[0], 8'($urandom));
    end
    settle("writes");
    for (int i = 0; i < 4; i++) begin
      xfer(ohp_pkg::RW_READ, 1'($urandom), 8'h00);
    end
    settle("reads");
    init_req_i = 1'b1;
    req_i = 1'b1;
    repeat (12) @(posedge clk_i);
    #1;
    check(10'(busy_o), 10'h0, "busy in init");
    check({2'b00, cmd_o}, 10'h0, "cmd after init");
    check({2'b00, wdata_o}, 10'h0, "data after init");
    req_i = 1'b0;
    init_req_i = 1'b0;
    repeat (6) @(posedge clk_i);
    xfer(ohp_pkg::RW_WRITE, ohp_pkg::DC_CMD, 8'h5a);
    settle("init");
    results();
  end
endmodule
